/* common/psfb_map.svh */
`ifndef PSFB_MAP_SVH
`define PSFB_MAP_SVH

// ----------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------
`define PSFB_AW 8
`define PSFB_DW 16

// ----------------------------------------------------------------
// Word addresses
// ----------------------------------------------------------------
`define PSFB_ADDR_W248  8'hF8
`define PSFB_ADDR_W249  8'hF9
`define PSFB_ADDR_W250  8'hFA
`define PSFB_ADDR_W251  8'hFB
`define PSFB_ADDR_CTRL  8'hFC
`define PSFB_ADDR_ALARM 8'hFD
`define PSFB_ADDR_SYSA  8'hFE
`define PSFB_ADDR_CLKC  8'hFF
`define PSFB_ADDR_PIO   8'h44
`define PSFB_ADDR_PORT1 8'h45
`define PSFB_ADDR_PORT2 8'h46
`define PSFB_ADDR_SW    8'h47
`define PSFB_ADDR_PWOFF 8'h57
`define PSFB_ADDR_SETUP 8'h80
`define PSFB_ADDR_FSET  8'h81
`define PSFB_ADDR_FRST  8'h82

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSFB_CTRL_FHOLD   11
`define PSFB_CTRL_IOHOLD  12
`define PSFB_CTRL_OUTOFF  15
`define PSFB_CTRL_MASK    16'h9800
`define PSFB_ALM_LOWBAT   8
`define PSFB_ALM_OVERRUN  9
`define PSFB_ALM_ON       13
`define PSFB_ALM_OFF      14
`define PSFB_ALM_FIRST    15
`define PSFB_SYSA_MIN     0
`define PSFB_SYSA_20MS    1
`define PSFB_SYSA_OVF     4
`define PSFB_SYSA_UNF     5
`define PSFB_SYSA_STEP    7
`define PSFB_SYSA_KEY     8
`define PSFB_SYSA_SEG     9
`define PSFB_SYSA_DIAL    10
`define PSFB_SYSA_PIOERR  15
`define PSFB_CLKC_100MS   0
`define PSFB_CLKC_200MS   1
`define PSFB_CLKC_1S      2
`define PSFB_CLKC_ERR     3
`define PSFB_CLKC_CARRY   4
`define PSFB_CLKC_GT      5
`define PSFB_CLKC_MATCH   6
`define PSFB_CLKC_LT      7
`define PSFB_SW_DIP6      12
`define PSFB_SETUP_RETAIN 0
`define PSFB_SETUP_NOBAT  1
`define PSFB_SETUP_NOOVR  2

// ----------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------
`define PSFB_FATAL_CODE   8'h9C
`define PSFB_CTRL_RESET   16'h0000
`define PSFB_CLK_PERIOD_NS 20
`define PSFB_TICK_NS      10000000
`define PSFB_TICK_CYCLES  ((`PSFB_TICK_NS) / (`PSFB_CLK_PERIOD_NS))
`define PSFB_TICK_MS      10
`define PSFB_HALF_MIN_MS  30000
`define PSFB_HALF_20MS_MS 10
`define PSFB_HALF_100MS_MS 50
`define PSFB_HALF_200MS_MS 100
`define PSFB_HALF_1S_MS   500

`endif

/* common/psfb_pkg.sv */
package psfb_pkg;

   typedef struct packed {
      logic [11:0] cnt;
      logic        wave;
   } psfb_sq_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } psfb_sync_s;

   typedef struct packed {
      logic [19:0] tick_cnt;
      logic        tick;
      logic [15:0] ctrl;
      logic [7:0]  alarm_code;
      logic        pio_err;
      logic        low_bat;
      logic        overrun;
      logic        first_pend;
      logic        first_cycle;
      logic        ovf;
      logic        unf;
      logic        err;
      logic        cout;
      logic        gt;
      logic        match;
      logic        lt;
      logic        step_pend;
      logic        step_flag;
      logic [7:0]  pio_code;
      logic [15:0] port1;
      logic [15:0] port2;
      logic        dip6;
      logic [15:0] pwoff;
      logic [2:0]  setup;
      logic [15:0] fset;
      logic [15:0] frst;
      logic [15:0] image;
      logic [15:0] outputs;
      logic        lamp;
      logic [15:0] rd_data;
   } psfb_state_s;

endpackage : psfb_pkg

/* rtl/psfb_sync.sv */
`timescale 1ns/1ps
`include "psfb_map.svh"

module psfb_sync (
   input  wire logic i_ref_clk,
   input  wire logic i_nrst,
   input  wire logic i_pin,
   output logic      o_level
);

   psfb_pkg::psfb_sync_s q;
   psfb_pkg::psfb_sync_s d;

   // ----------------------------------------------------------------
   // Three stages, change taken once the last two agree
   // ----------------------------------------------------------------
   always_comb begin
      d    = q;
      d.s1 = i_pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.out = q.s3;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_level = q.out;

endmodule : psfb_sync

/* rtl/psfb_sqwave.sv */
`timescale 1ns/1ps
`include "psfb_map.svh"

module psfb_sqwave #(
   parameter logic [11:0] HALF_TICKS = 12'h0001
) (
   input  wire logic i_ref_clk,
   input  wire logic i_nrst,
   input  wire logic i_tick,
   output logic      o_wave
);

   psfb_pkg::psfb_sq_s q;
   psfb_pkg::psfb_sq_s d;

   // ----------------------------------------------------------------
   // Half period counted in shared ticks keeps duty exact
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      if (i_tick) begin
         if (q.cnt == HALF_TICKS - 12'h0001) begin
            d.cnt  = '0;
            d.wave = ~q.wave;
         end else begin
            d.cnt = q.cnt + 12'h0001;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_wave = q.wave;

endmodule : psfb_sqwave

/* rtl/psfb_top.sv */
`timescale 1ns/1ps
`include "psfb_map.svh"


module psfb_top #(
   parameter logic [19:0] TICK_CYCLES = 20'(`PSFB_TICK_CYCLES)
) (
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_nrst,
   // Register port
   input  wire logic [`PSFB_AW-1:0]   i_addr,
   input  wire logic [`PSFB_DW-1:0]   i_wr_data,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [`PSFB_DW-1:0]   o_rd_data,
   // Scan and mode events
   input  wire logic                  i_scan_tick,
   input  wire logic                  i_run_entry,
   input  wire logic                  i_monitor_entry,
   input  wire logic                  i_op_change,
   input  wire logic                  i_power_up,
   input  wire logic                  i_error_clear,
   input  wire logic                  i_scan_overrun,
   // Instruction results
   input  wire logic                  i_instr_strobe,
   input  wire logic                  i_calc_overflow,
   input  wire logic                  i_calc_underflow,
   input  wire logic                  i_instr_error,
   input  wire logic                  i_carry,
   input  wire logic                  i_cmp_gt,
   input  wire logic                  i_cmp_match,
   input  wire logic                  i_cmp_lt,
   input  wire logic                  i_result_zero,
   input  wire logic                  i_step_start,
   input  wire logic                  i_hex_keypad_instr,
   input  wire logic                  i_digit_display_instr,
   input  wire logic                  i_thumbwheel_read_instr,
   // Pulse and counter engines
   input  wire logic                  i_port1_fault,
   input  wire logic                  i_port2_fault,
   input  wire logic [7:0]            i_pio_status_code,
   input  wire logic [3:0]            i_port1_pulse,
   input  wire logic [3:0]            i_port2_pulse,
   input  wire logic [1:0]            i_cnt1_flags,
   input  wire logic [1:0]            i_cnt2_flags,
   // Pins
   input  wire logic                  i_battery_low_pin,
   input  wire logic                  i_dip6_pin,
   // Output image and alarms
   input  wire logic [15:0]           i_prog_outputs,
   output logic      [15:0]           o_outputs,
   output logic                       o_outputs_blocked_lamp,
   output logic                       o_fatal_alarm,
   output logic      [7:0]            o_alarm_code
);

   psfb_pkg::psfb_state_s q;
   psfb_pkg::psfb_state_s d;

   logic        w_min;
   logic        w_20ms;
   logic        w_100ms;
   logic        w_200ms;
   logic        w_1s;
   logic        bat_level;
   logic        dip_level;
   logic [15:0] rel_set;
   logic [15:0] rel_rst;
   logic [15:0] word_alarm;
   logic [15:0] word_sysa;
   logic [15:0] word_clkc;

   // ----------------------------------------------------------------
   // Clock pulse generators
   // ----------------------------------------------------------------
   // One tick feeds every divider so all edges line up
   psfb_sqwave #(.HALF_TICKS(12'(`PSFB_HALF_MIN_MS / `PSFB_TICK_MS)))
   u_sq_min (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_tick    (q.tick),
      .o_wave    (w_min)
   );

   psfb_sqwave #(.HALF_TICKS(12'(`PSFB_HALF_20MS_MS / `PSFB_TICK_MS)))
   u_sq_20ms (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_tick    (q.tick),
      .o_wave    (w_20ms)
   );

   psfb_sqwave #(.HALF_TICKS(12'(`PSFB_HALF_100MS_MS / `PSFB_TICK_MS)))
   u_sq_100ms (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_tick    (q.tick),
      .o_wave    (w_100ms)
   );

   psfb_sqwave #(.HALF_TICKS(12'(`PSFB_HALF_200MS_MS / `PSFB_TICK_MS)))
   u_sq_200ms (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_tick    (q.tick),
      .o_wave    (w_200ms)
   );

   psfb_sqwave #(.HALF_TICKS(12'(`PSFB_HALF_1S_MS / `PSFB_TICK_MS)))
   u_sq_1s (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_tick    (q.tick),
      .o_wave    (w_1s)
   );

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   psfb_sync u_sync_bat (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_pin     (i_battery_low_pin),
      .o_level   (bat_level)
   );

   psfb_sync u_sync_dip (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_pin     (i_dip6_pin),
      .o_level   (dip_level)
   );

   // ----------------------------------------------------------------
   // Read-only word assembly
   // ----------------------------------------------------------------
   always_comb begin
      word_alarm                    = '0;
      word_alarm[7:0]               = q.alarm_code;
      word_alarm[`PSFB_ALM_LOWBAT]  = q.low_bat;
      word_alarm[`PSFB_ALM_OVERRUN] = q.overrun;
      word_alarm[`PSFB_ALM_ON]      = 1'b1;
      word_alarm[`PSFB_ALM_OFF]     = 1'b0;
      word_alarm[`PSFB_ALM_FIRST]   = q.first_cycle;

      word_sysa                     = '0;
      word_sysa[`PSFB_SYSA_MIN]     = w_min;
      word_sysa[`PSFB_SYSA_20MS]    = w_20ms;
      word_sysa[`PSFB_SYSA_OVF]     = q.ovf;
      word_sysa[`PSFB_SYSA_UNF]     = q.unf;
      word_sysa[`PSFB_SYSA_STEP]    = q.step_flag;
      word_sysa[`PSFB_SYSA_KEY]     = i_hex_keypad_instr;
      word_sysa[`PSFB_SYSA_SEG]     = i_digit_display_instr;
      word_sysa[`PSFB_SYSA_DIAL]    = i_thumbwheel_read_instr;
      word_sysa[`PSFB_SYSA_PIOERR]  = q.pio_err;

      word_clkc                     = '0;
      word_clkc[`PSFB_CLKC_100MS]   = w_100ms;
      word_clkc[`PSFB_CLKC_200MS]   = w_200ms;
      word_clkc[`PSFB_CLKC_1S]      = w_1s;
      word_clkc[`PSFB_CLKC_ERR]     = q.err;
      word_clkc[`PSFB_CLKC_CARRY]   = q.cout;
      word_clkc[`PSFB_CLKC_GT]      = q.gt;
      word_clkc[`PSFB_CLKC_MATCH]   = q.match;
      word_clkc[`PSFB_CLKC_LT]      = q.lt;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d       = q;
      rel_set = '0;
      rel_rst = '0;

      // Shared time base
      d.tick = 1'b0;
      if (q.tick_cnt >= TICK_CYCLES - 20'h0_0001) begin
         d.tick_cnt = '0;
         d.tick     = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 20'h0_0001;
      end

      // Condition flags follow each completed instruction
      if (i_instr_strobe) begin
         d.ovf = i_calc_overflow;
         d.unf = i_calc_underflow;
         d.err = i_instr_error;
         d.cout = i_carry;
         d.gt  = i_cmp_gt;
         d.match = i_cmp_match | i_result_zero;
         d.lt  = i_cmp_lt;
      end

      // One-scan flags: a start in the boundary cycle is kept
      if (i_scan_tick) begin
         d.step_flag   = q.step_pend;
         d.step_pend   = 1'b0;
         d.first_cycle = q.first_pend;
         d.first_pend  = 1'b0;
      end
      if (i_step_start) begin
         d.step_pend = 1'b1;
      end

      // Error clear first, so a fault in the same cycle wins
      if (i_error_clear) begin
         d.pio_err    = 1'b0;
         d.alarm_code = '0;
         d.low_bat    = 1'b0;
         d.overrun    = 1'b0;
      end
      if (i_port1_fault | i_port2_fault) begin
         d.pio_err    = 1'b1;
         d.alarm_code = `PSFB_FATAL_CODE;
      end
      if (bat_level & ~q.setup[`PSFB_SETUP_NOBAT]) begin
         d.low_bat = 1'b1;
      end
      if (i_scan_overrun & ~q.setup[`PSFB_SETUP_NOOVR]) begin
         d.overrun = 1'b1;
      end

      // Aux words sampled once per scan; pwoff counts power-ups
      if (i_scan_tick) begin
         d.pio_code = i_pio_status_code;
         d.port1    = {i_port1_pulse, 2'b00, i_cnt1_flags, 8'h00};
         d.port2    = {i_port2_pulse, 2'b00, i_cnt2_flags, 8'h00};
         d.dip6     = dip_level;
      end
      if (i_power_up) begin
         d.pwoff = q.pwoff + 16'h0001;
      end

      // Register writes; system words other than control are ignored
      if (i_wr) begin
         case (i_addr)
            `PSFB_ADDR_CTRL: begin
               d.ctrl = i_wr_data & `PSFB_CTRL_MASK;
            end
            `PSFB_ADDR_SETUP: begin
               d.setup = i_wr_data[2:0];
            end
            `PSFB_ADDR_FSET: begin
               d.fset = i_wr_data;
            end
            `PSFB_ADDR_FRST: begin
               d.frst = i_wr_data;
            end
            default: begin
               d.ctrl = d.ctrl;
            end
         endcase
      end

      // Hold bits lost at power-up unless retention is enabled
      if (i_power_up & ~q.setup[`PSFB_SETUP_RETAIN]) begin
         d.ctrl[`PSFB_CTRL_FHOLD]  = 1'b0;
         d.ctrl[`PSFB_CTRL_IOHOLD] = 1'b0;
      end

      // Force release on run entry, and on monitor entry unless force hold is set
      if (i_monitor_entry & ~q.ctrl[`PSFB_CTRL_FHOLD]) begin
         d.fset = '0;
         d.frst = '0;
      end
      if (i_run_entry) begin
         d.fset       = '0;
         d.frst       = '0;
         d.first_pend = 1'b1;
      end

      // Output image, refreshed at scan end
      if (i_op_change & ~q.ctrl[`PSFB_CTRL_IOHOLD]) begin
         d.image = '0;
      end else if (i_scan_tick) begin
         d.image = i_prog_outputs;
      end

      // Released bits keep their forced level until the program rewrites them
      rel_set = q.fset & ~d.fset;
      rel_rst = q.frst & ~d.frst;
      d.image = (d.image | rel_set) & ~rel_rst;

      // Inhibit overrides program and force alike
      if (d.ctrl[`PSFB_CTRL_OUTOFF]) begin
         d.outputs = '0;
      end else begin
         d.outputs = (d.image | d.fset) & ~d.frst;
      end
      d.lamp = d.ctrl[`PSFB_CTRL_OUTOFF];

      // Read data stands only in the cycle after the strobe
      d.rd_data = '0;
      if (i_rd) begin
         case (i_addr)
            `PSFB_ADDR_CTRL:  d.rd_data = q.ctrl;
            `PSFB_ADDR_ALARM: d.rd_data = word_alarm;
            `PSFB_ADDR_SYSA:  d.rd_data = word_sysa;
            `PSFB_ADDR_CLKC:  d.rd_data = word_clkc;
            `PSFB_ADDR_PIO:   d.rd_data = {q.pio_code, 8'h00};
            `PSFB_ADDR_PORT1: d.rd_data = q.port1;
            `PSFB_ADDR_PORT2: d.rd_data = q.port2;
            `PSFB_ADDR_SW:    d.rd_data = 16'(q.dip6) << `PSFB_SW_DIP6;
            `PSFB_ADDR_PWOFF: d.rd_data = q.pwoff;
            `PSFB_ADDR_SETUP: d.rd_data = {13'h0000, q.setup};
            `PSFB_ADDR_FSET:  d.rd_data = q.fset;
            `PSFB_ADDR_FRST:  d.rd_data = q.frst;
            default:          d.rd_data = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_rd_data              = q.rd_data;
   assign o_outputs              = q.outputs;
   assign o_outputs_blocked_lamp = q.lamp;
   assign o_fatal_alarm          = q.pio_err;
   assign o_alarm_code           = q.alarm_code;

endmodule : psfb_top

/* test/psfb_scan_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Program side: one scan end pulse every SCAN clocks while enabled
// ----------------------------------------------------------------
module psfb_scan_model #(
   parameter int SCAN = 16
) (
   input  wire logic i_ref_clk,
   input  wire logic i_nrst,
   input  wire logic i_en,
   output logic      o_scan_tick
);
   logic [7:0] cnt_q;
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q       <= 8'h00;
         o_scan_tick <= 1'b0;
      end else begin
         cnt_q       <= (cnt_q == 8'(SCAN - 1)) ? 8'h00 : cnt_q + 8'h01;
         o_scan_tick <= i_en && (cnt_q == 8'(SCAN - 1));
      end
   end
endmodule : psfb_scan_model

/* test/psfb_top_assertions.sv */
`timescale 1ns/1ps
`include "psfb_map.svh"

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module psfb_top_assertions (
   input wire logic        i_ref_clk,
   input wire logic        i_nrst,
   input wire logic [7:0]  i_addr,
   input wire logic [15:0] i_wr_data,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rd_data,
   input wire logic        i_error_clear,
   input wire logic        i_port1_fault,
   input wire logic        i_port2_fault,
   input wire logic        i_hex_keypad_instr,
   input wire logic        i_digit_display_instr,
   input wire logic        i_thumbwheel_read_instr,
   input wire logic [15:0] o_outputs,
   input wire logic        o_outputs_blocked_lamp,
   input wire logic        o_fatal_alarm,
   input wire logic [7:0]  o_alarm_code
);
   wire logic [2:0] busy = {i_thumbwheel_read_instr, i_digit_display_instr, i_hex_keypad_instr};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   chk_lamp_follows_write: assert property (i_wr && i_addr == `PSFB_ADDR_CTRL
      |=> o_outputs_blocked_lamp == $past(i_wr_data[15])) else $error("lamp not as written");
   chk_lamp_rise_cause: assert property ($rose(o_outputs_blocked_lamp)
      |-> $past(i_wr) && $past(i_addr) == `PSFB_ADDR_CTRL) else $error("lamp rose unasked");
   chk_outputs_blocked: assert property (o_outputs_blocked_lamp |-> o_outputs == 16'h0000)
      else $error("outputs on while blocked");
   chk_fault_raises: assert property (i_port1_fault || i_port2_fault
      |=> ##[0:1] o_fatal_alarm) else $error("fault not raised");
   chk_alarm_code: assert property (o_fatal_alarm |-> o_alarm_code == `PSFB_FATAL_CODE)
      else $error("wrong alarm code");
   chk_alarm_clear: assert property (i_error_clear && !i_port1_fault && !i_port2_fault
      |=> ##1 !o_fatal_alarm && o_alarm_code == 8'h00) else $error("alarm not cleared");
   chk_busy_bits: assert property (i_rd && i_addr == `PSFB_ADDR_SYSA && $stable(busy)
      |=> o_rd_data[10:8] == $past(busy)) else $error("busy bits wrong");
   chk_unused_read: assert property (i_rd && i_addr >= `PSFB_ADDR_W248 && i_addr <= `PSFB_ADDR_W251
      |=> o_rd_data == 16'h0000) else $error("unused word not zero");
endmodule : psfb_top_assertions

bind psfb_top psfb_top_assertions u_chk (.i_ref_clk, .i_nrst, .i_addr,
   .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_error_clear, .i_port1_fault, .i_port2_fault,
   .i_hex_keypad_instr, .i_digit_display_instr, .i_thumbwheel_read_instr, .o_outputs,
   .o_outputs_blocked_lamp, .o_fatal_alarm, .o_alarm_code);

/* test/tb_top.sv */
`timescale 1ns/1ps
`include "psfb_map.svh"

// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module tb_top;
   localparam int TK = 4;
   logic        i_ref_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic [7:0]  i_addr, i_pio_status_code, v, o_alarm_code;
   logic [15:0] i_wr_data, i_prog_outputs, o_rd_data, o_outputs;
   logic        i_wr, i_rd, i_run_entry, i_error_clear, i_scan_overrun, i_instr_strobe, i_step_start, en, scan;
   logic        i_hex_keypad_instr, i_digit_display_instr, i_thumbwheel_read_instr, i_port1_fault, i_port2_fault;
   logic        i_battery_low_pin, i_dip6_pin, o_outputs_blocked_lamp, o_fatal_alarm, i_power_up;
   logic [3:0]  i_port1_pulse, i_port2_pulse;
   logic [1:0]  i_cnt1_flags, i_cnt2_flags;
   int          num_errors = 0;
   int          n_compared = 0;
   always #10 i_ref_clk = ~i_ref_clk;
   psfb_scan_model u_scan (.i_ref_clk, .i_nrst, .i_en(en), .o_scan_tick(scan));
   psfb_top #(.TICK_CYCLES(20'h0_0004)) u_dut (.i_ref_clk, .i_nrst, .i_addr, .i_wr_data, .i_wr, .i_rd,
      .o_rd_data, .i_scan_tick(scan), .i_run_entry, .i_monitor_entry(1'b0), .i_op_change(1'b0),
      .i_power_up, .i_error_clear, .i_scan_overrun, .i_instr_strobe, .i_calc_overflow(v[0]),
      .i_calc_underflow(v[1]), .i_instr_error(v[2]), .i_carry(v[3]), .i_cmp_gt(v[4]), .i_cmp_match(v[5]),
      .i_cmp_lt(v[6]), .i_result_zero(v[7]), .i_step_start, .i_hex_keypad_instr, .i_digit_display_instr,
      .i_thumbwheel_read_instr, .i_port1_fault, .i_port2_fault, .i_pio_status_code, .i_port1_pulse,
      .i_port2_pulse, .i_cnt1_flags, .i_cnt2_flags, .i_battery_low_pin, .i_dip6_pin, .i_prog_outputs,
      .o_outputs, .o_outputs_blocked_lamp, .o_fatal_alarm, .o_alarm_code);

   task summarize;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask : cyc
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 chk(o_rd_data & m, e);
   endtask : rd
   // Bounded: a stopped source must not hang
   task wtick;
      int i;
      for (i = 0; i < 100; i++) begin
         @(posedge i_ref_clk);
         if (scan === 1'b1) break;
      end
      if (i == 100) begin
         num_errors++;
         summarize;
      end
   endtask : wtick
   task t_regs;
      rd(8'hFC, 16'hFFFF, 16'h0000);
      wr(8'hFD, 16'hFFFF);
      wr(8'hFE, 16'hFFFF);
      wr(8'hFF, 16'hFFFF);
      wr(8'hF8, 16'hFFFF);
      rd(8'hFD, 16'hFFFF, 16'h2000);
      rd(8'hFE, 16'hFFFC, 16'h0000);
      rd(8'hFF, 16'hFFF8, 16'h0000);
      rd(8'hF8, 16'hFFFF, 16'h0000);
      rd(8'h10, 16'hFFFF, 16'h0000);
      wr(8'hFC, 16'hFFFF);
      rd(8'hFC, 16'hFFFF, 16'h9800);
      chk({o_outputs_blocked_lamp, o_outputs[14:0]}, 16'h8000);
      wr(8'hFC, 16'h1800);
      wtick;
      cyc(2);
      chk(o_outputs, 16'h00FF);
   endtask : t_regs
   task t_flags;
      for (int i = 0; i < 8; i++) begin
         @(posedge i_ref_clk);
         v <= 8'h01 << i;
         i_instr_strobe <= 1'b1;
         @(posedge i_ref_clk);
         i_instr_strobe <= 1'b0;
         rd(8'hFF, 16'h00F8, {8'h00, v[6], v[5] | v[7], v[4], v[3], v[2], 3'b000});
         rd(8'hFE, 16'h0030, {10'h000, v[1], v[0], 4'h0});
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge i_ref_clk);
         {i_thumbwheel_read_instr, i_digit_display_instr, i_hex_keypad_instr} <= 3'b001 << i;
         rd(8'hFE, 16'h0700, 16'h0100 << i);
      end
   endtask : t_flags
   task t_step;
      @(posedge i_ref_clk);
      i_step_start <= 1'b1;
      @(posedge i_ref_clk);
      i_step_start <= 1'b0;
      wtick;
      rd(8'hFE, 16'h0080, 16'h0080);
      wtick;
      rd(8'hFE, 16'h0080, 16'h0000);
   endtask : t_step
   task t_fault;
      for (int i = 0; i < 2; i++) begin
         @(posedge i_ref_clk);
         i_port1_fault <= (i == 0);
         i_port2_fault <= (i == 1);
         @(posedge i_ref_clk);
         {i_port1_fault, i_port2_fault} <= 2'b00;
         rd(8'hFE, 16'h8000, 16'h8000);
         chk({o_fatal_alarm, 7'h00, o_alarm_code}, 16'h809C);
         @(posedge i_ref_clk);
         i_error_clear <= 1'b1;
         @(posedge i_ref_clk);
         i_error_clear <= 1'b0;
         cyc(2);
         chk({o_fatal_alarm, 7'h00, o_alarm_code}, 16'h0000);
      end
   endtask : t_fault
   task t_aux;
      @(posedge i_ref_clk);
      {i_port1_pulse, i_cnt1_flags, i_port2_pulse, i_cnt2_flags, i_dip6_pin} <= 13'b1010_01_0101_10_1;
      for (int i = 0; i < 5; i++) begin
         @(posedge i_ref_clk);
         i_pio_status_code <= 8'(i);
         cyc(5);
         wtick;
         rd(8'h44, 16'hFFFF, {8'(i), 8'h00});
      end
      rd(8'h45, 16'hFFFF, 16'hA100);
      rd(8'h46, 16'hFFFF, 16'h5200);
      rd(8'h47, 16'hFFFF, 16'h1000);
   endtask : t_aux
   task t_errsup;
      @(posedge i_ref_clk);
      i_scan_overrun <= 1'b1;
      @(posedge i_ref_clk);
      i_scan_overrun <= 1'b0;
      rd(8'hFD, 16'h0300, 16'h0200);
      wr(8'h80, 16'h0006);
      @(posedge i_ref_clk);
      i_error_clear <= 1'b1;
      i_battery_low_pin <= 1'b1;
      i_power_up <= 1'b1;
      @(posedge i_ref_clk);
      i_error_clear <= 1'b0;
      i_scan_overrun <= 1'b1;
      i_power_up <= 1'b0;
      @(posedge i_ref_clk);
      i_scan_overrun <= 1'b0;
      cyc(6);
      rd(8'hFD, 16'h0300, 16'h0000);
      rd(8'hFC, 16'hFFFF, 16'h0000);
      rd(8'h57, 16'hFFFF, 16'h0001);
      wr(8'h80, 16'h0000);
      cyc(2);
      rd(8'hFD, 16'h0100, 16'h0100);
   endtask : t_errsup
   task t_force;
      @(posedge i_ref_clk);
      en <= 1'b0;
      i_battery_low_pin <= 1'b0;
      i_prog_outputs <= 16'h00F0;
      wr(8'h81, 16'h000F);
      wr(8'h82, 16'h00F0);
      @(posedge i_ref_clk);
      en <= 1'b1;
      wtick;
      en <= 1'b0;
      cyc(2);
      chk(o_outputs, 16'h000F);
      @(posedge i_ref_clk);
      i_run_entry <= 1'b1;
      @(posedge i_ref_clk);
      i_run_entry <= 1'b0;
      cyc(2);
      chk(o_outputs, 16'h000F);
      rd(8'h81, 16'hFFFF, 16'h0000);
      rd(8'h82, 16'hFFFF, 16'h0000);
      @(posedge i_ref_clk);
      en <= 1'b1;
      wtick;
      cyc(2);
      chk(o_outputs, 16'h00F0);
   endtask : t_force
   // Times one half period of a clock bit
   task t_wave(input logic [7:0] a, input int b, input int h);
      int  i, k, n;
      logic p;
      k = 0;
      n = 0;
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      cyc(2);
      p = o_rd_data[b];
      for (i = 0; i < 40000 && k < 2; i++) begin
         cyc(1);
         if (o_rd_data[b] !== p) begin
            k++;
            p = o_rd_data[b];
            if (k == 2) chk(16'(n), 16'(h));
            n = 0;
         end
         n++;
      end
      i_rd <= 1'b0;
      if (k < 2) begin
         num_errors++;
         summarize;
      end
   endtask : t_wave

   initial begin
      {i_addr, i_wr_data, i_wr, i_rd, i_run_entry, i_error_clear, i_scan_overrun, v} = '0;
      {i_instr_strobe, i_step_start, i_hex_keypad_instr, i_digit_display_instr, i_thumbwheel_read_instr} = '0;
      {i_port1_fault, i_port2_fault, i_pio_status_code, i_port1_pulse, i_port2_pulse} = '0;
      {i_cnt1_flags, i_cnt2_flags, i_battery_low_pin, i_dip6_pin, i_power_up} = '0;
      i_prog_outputs = 16'h00FF;
      en = 1'b1;
      repeat (6) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      t_regs;
      t_flags;
      t_step;
      t_fault;
      t_aux;
      t_errsup;
      t_force;
      t_wave(8'hFE, 1, TK);
      t_wave(8'hFF, 0, 5 * TK);
      t_wave(8'hFF, 1, 10 * TK);
      t_wave(8'hFF, 2, 50 * TK);
      t_wave(8'hFE, 0, 3000 * TK);
      summarize;
   end
endmodule : tb_top
